// >>> rtl/ltx_pkg.sv
// Purpose: Shared constants of the transmit data port.
// Assumes: 200 MHz system clock, byte-addressed 32-bit register port.
// Notes:   One localparam per offset, field, reset value and count.
package ltx_pkg;
	// ==========================================================
	// Structure
	localparam int NUM_CHAN = 8;
	localparam int REF_CHAN = 1;
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 32;

	// ==========================================================
	// Register map
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_OE     = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam int CTRL_W     = 5;
	localparam int CTRL_DUAL  = 0;
	localparam int CTRL_AMI   = 1;
	localparam int CTRL_MODE2 = 2;
	localparam int CTRL_E1    = 3;
	localparam int CTRL_HOST  = 4;
	localparam int CFG_W      = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [7:0] OE_RESET   = 8'h00;
	localparam int STAT_ONES = 0;
	localparam int STAT_PDN  = 8;
	localparam int STAT_TCLK = 16;
	localparam int STAT_MCLK = 24;

	// ==========================================================
	// Line coding
	localparam int B8ZS_DEPTH = 8;
	localparam int HDB3_DEPTH = 4;
	localparam logic [7:0] B8ZS_SUB_B  = 8'h09;
	localparam logic [7:0] B8ZS_SUB_V  = 8'h12;
	localparam logic [7:0] HDB3_SUB_B  = 8'h08;
	localparam logic [7:0] HDB3_SUB_V  = 8'h01;
	localparam logic [7:0] HDB3_MASK   = 8'h0F;
	localparam logic [7:0] B8ZS_MASK   = 8'hFF;

	// ==========================================================
	// Timing
	localparam int HIGH_STALL_TICKS = 16;
	localparam int LOW_STALL_TICKS  = 64;
	localparam int STALL_CNT_W      = 7;
	localparam int CLK_PERIOD_PS    = 5000;
	localparam int MCLK_LOSS_NS     = 2000;
	localparam int MCLK_LOSS_CYCLES =
		(MCLK_LOSS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MCLK_CNT_W = 10;
endpackage

// >>> rtl/ltx_line_encoder.sv
// Purpose: Per-channel transmit capture and line coder, link clock domain.
// Assumes: Configuration levels change only while the channel is idle.
// Notes:   All logic runs on the falling edge of the channel clock.
`timescale 1ns/10ps
module ltx_line_encoder (
	input  wire logic                    txClk,
	input  wire logic                    sysRst,
	input  wire logic                    txSerial,
	input  wire logic                    txPosRail,
	input  wire logic                    txNegRail,
	input  wire logic                    violIn,
	input  wire logic [ltx_pkg::CFG_W-1:0] cfgIn,
	output logic                         encPos,
	output logic                         encNeg
);
	logic                        rstMeta, rstSync;
	logic [ltx_pkg::CFG_W-1:0]   cfgMeta, cfgSync;
	logic [7:0]                  dly, kindB, kindV;
	logic                        lastPos, parity, violPrev, violPend;

	// ==========================================================
	// Crossing into the link domain
	always_ff @(negedge txClk) begin
		rstMeta <= sysRst;
		rstSync <= rstMeta;
		cfgMeta <= cfgIn;
		cfgSync <= cfgMeta;
	end

	// ==========================================================
	// Decode
	wire       dualRail = cfgSync[ltx_pkg::CTRL_DUAL];
	wire       amiSel   = cfgSync[ltx_pkg::CTRL_AMI];
	wire       e1Sel    = cfgSync[ltx_pkg::CTRL_E1];
	wire       violOk   = ~dualRail & amiSel &
		cfgSync[ltx_pkg::CTRL_MODE2];                      // RULE3
	wire [2:0] tapIdx   = e1Sel ? 3'(ltx_pkg::HDB3_DEPTH - 1)
		: 3'(ltx_pkg::B8ZS_DEPTH - 1);
	wire [7:0] winD     = {dly[6:0], txSerial};
	wire [7:0] winB     = {kindB[6:0], 1'b0};
	wire [7:0] winV     = {kindV[6:0], 1'b0};
	wire [7:0] zeroMask = e1Sel ? ltx_pkg::HDB3_MASK : ltx_pkg::B8ZS_MASK;
	wire       outD     = dly[tapIdx];
	wire       outB     = kindB[tapIdx];
	wire       outV     = kindV[tapIdx];
	wire       isMark   = outD | outB | outV;
	wire       dataOne  = outD & ~outB & ~outV;
	wire       violRise = violIn & ~violPrev;
	wire       sameSign = outV | (dataOne & violPend & violOk); // RULE4
	wire       markPos  = sameSign ? lastPos : ~lastPos;
	wire       parNext  = outV ? 1'b0 : (parity ^ isMark);
	// Substitution only when the whole window holds plain zeros
	wire       subNow   = ~amiSel &
		(((winD | winB | winV) & zeroMask) == 8'h00);        // RULE2
	wire [7:0] subB     = !subNow ? 8'h00 : (e1Sel ?
		(parNext ? 8'h00 : ltx_pkg::HDB3_SUB_B) : ltx_pkg::B8ZS_SUB_B);
	wire [7:0] subV     = !subNow ? 8'h00 : (e1Sel ?
		ltx_pkg::HDB3_SUB_V : ltx_pkg::B8ZS_SUB_V);
	wire       dualPos  = txPosRail & ~txNegRail;          // RULE6
	wire       dualNeg  = txNegRail & ~txPosRail;          // RULE6

	// ==========================================================
	// Capture and coding
	always_ff @(negedge txClk) begin
		if (rstSync) begin
			dly      <= 8'h00;
			kindB    <= 8'h00;
			kindV    <= 8'h00;
			lastPos  <= 1'b0;
			parity   <= 1'b0;
			violPrev <= 1'b0;
			violPend <= 1'b0;
			encPos   <= 1'b0;
			encNeg   <= 1'b0;
		end else begin
			dly      <= winD;                              // RULE1
			kindB    <= winB | subB;
			kindV    <= winV | subV;
			violPrev <= violIn;
			if (violRise && violOk)
				violPend <= 1'b1;                          // RULE4
			else if (!violOk || dataOne)
				violPend <= 1'b0;                          // RULE3
			if (isMark)
				lastPos <= markPos;
			parity   <= parNext;
			encPos   <= dualRail ? dualPos : (isMark & markPos); // RULE5
			encNeg   <= dualRail ? dualNeg : (isMark & ~markPos);
		end
	end

	// ==========================================================
	// Checks
	// System reset masks the first link edges, before rstSync is known
	a_dual_rail_map: assert property (         // RULE6
		@(negedge txClk) disable iff (sysRst || rstSync)
		dualRail |=> encPos == $past(dualPos) && encNeg == $past(dualNeg))
		else $error("dual rail pair mapped wrongly");
	a_rails_exclusive: assert property (       // RULE6
		@(negedge txClk) disable iff (sysRst || rstSync)
		!(encPos && encNeg))
		else $error("both line rails driven at once");
	a_viol_ignored: assert property (          // RULE3
		@(negedge txClk) disable iff (sysRst || rstSync)
		!violOk |=> !violPend)
		else $error("violation request kept outside AMI mode 2");
	a_viol_repeat: assert property (           // RULE4
		@(negedge txClk) disable iff (sysRst || rstSync)
		violPend && violOk && dataOne
		|=> (encPos || encNeg) && encPos == $past(lastPos))
		else $error("inserted violation did not repeat polarity");
endmodule

// >>> rtl/ltx_clock_watch.sv
// Purpose: Transmit clock stall monitor for one channel.
// Assumes: refTick and tclkEdge are one-cycle pulses of the system clock.
// Notes:   Count saturates, so long stalls never wrap back to normal.
`timescale 1ns/10ps
module ltx_clock_watch #(
	parameter int HIGH_TICKS = ltx_pkg::HIGH_STALL_TICKS,
	parameter int LOW_TICKS  = ltx_pkg::LOW_STALL_TICKS
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic refTick,
	input  wire logic tclkLevel,
	input  wire logic tclkEdge,
	output logic      allOnes_reg,
	output logic      powerDown_reg
);
	localparam int CW = ltx_pkg::STALL_CNT_W;
	logic [CW-1:0] cnt_reg;
	wire           cntFull    = &cnt_reg;
	wire           highStall  = tclkLevel && (cnt_reg >= CW'(HIGH_TICKS));
	wire           lowStall   = !tclkLevel && (cnt_reg >= CW'(LOW_TICKS));

	always_ff @(posedge clock) begin
		if (sys_rst || tclkEdge)
			cnt_reg <= '0;                                 // RULE13
		else if (refTick && !cntFull)
			cnt_reg <= cnt_reg + CW'(1);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			allOnes_reg   <= 1'b0;
			powerDown_reg <= 1'b0;
		end else begin
			allOnes_reg   <= highStall;                    // RULE7
			powerDown_reg <= lowStall;                     // RULE9
		end
	end

	a_stall_high: assert property (            // RULE7
		@(posedge clock) disable iff (sys_rst)
		$rose(allOnes_reg) |-> $past(tclkLevel)
			&& $past(cnt_reg) >= CW'(HIGH_TICKS))
		else $error("all ones entered too early");
	a_stall_low: assert property (             // RULE9
		@(posedge clock) disable iff (sys_rst)
		$rose(powerDown_reg) |-> !$past(tclkLevel)
			&& $past(cnt_reg) >= CW'(LOW_TICKS))
		else $error("power down entered too early");
	a_edge_restart: assert property (          // RULE13
		@(posedge clock) disable iff (sys_rst)
		tclkEdge |=> cnt_reg == '0 ##1 !allOnes_reg && !powerDown_reg)
		else $error("clock edge did not restore normal operation");
endmodule

// >>> rtl/ltx_tx_port.sv
// Purpose: Transmit digital interface of the multi-channel line port.
// Assumes: Channel clocks are unrelated to clock; reference clock is slow.
// Notes:   Line pins are registered in the system clock domain.
//
// Overview of operation
// RULE1: Single-rail data captured on channel clock falling edge
// RULE2: Single-rail data coded AMI or B8ZS/HDB3
// RULE3: Violation insert only in AMI mode 2
// RULE4: Violation rise repeats polarity of next one
// RULE5: Dual-rail pair captured on falling clock edges
// RULE6: Dual-rail map: 00 space, 01 neg, 10 pos
// RULE7: Clock high 16 reference ticks sends all ones
// RULE8: All-ones pattern timed from reference clock
// RULE9: Clock low 64 ticks powers down, high-Z
// RULE10: Static reference clock uses channel one clock
// RULE11: Output enable low or stalled low: high-Z
// RULE12: Host mode enable-register bit forces high-Z
// RULE13: Clock edges restart counters, restore normal
`timescale 1ns/10ps
module ltx_tx_port #(
	parameter int NCH       = ltx_pkg::NUM_CHAN,
	parameter int MCLK_LOSS = ltx_pkg::MCLK_LOSS_CYCLES
) (
	input  wire logic                      clock,
	input  wire logic                      sys_rst,
	input  wire logic [ltx_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [ltx_pkg::DATA_W-1:0] regWrData,
	input  wire logic                      regWrite,
	input  wire logic                      regRead,
	output logic [ltx_pkg::DATA_W-1:0]     regRdData,
	input  wire logic                      masterRefClock,
	input  wire logic                      outputEnableIn,
	input  wire logic [NCH-1:0]            chanTxClock,
	input  wire logic [NCH-1:0]            txSerialIn,
	input  wire logic [NCH-1:0]            txPosRailIn,
	input  wire logic [NCH-1:0]            txNegRailIn,
	input  wire logic [NCH-1:0]            violationInsertIn,
	output logic [NCH-1:0]                 lineDrivePos,
	output logic [NCH-1:0]                 lineDriveNeg,
	output logic [NCH-1:0]                 lineDriveEnable,
	output logic [NCH-1:0]                 allOnesSend
);
	localparam int DW = ltx_pkg::DATA_W;
	localparam int MW = ltx_pkg::MCLK_CNT_W;

	// ==========================================================
	// Register file
	logic [ltx_pkg::CTRL_W-1:0] ctrl_reg;
	logic [NCH-1:0]             oeForce_reg;
	logic [DW-1:0]              regRdData_reg;
	logic [DW-1:0]              rdMux;
	logic [NCH-1:0]             powerDown;
	logic [NCH-1:0]             allOnesNow;
	logic                       mclkRunning_reg;
	logic [NCH-1:0]             tclkSync;

	wire selCtrl   = regAddr == ltx_pkg::ADDR_CTRL;
	wire selOe     = regAddr == ltx_pkg::ADDR_OE;
	wire selStatus = regAddr == ltx_pkg::ADDR_STATUS;
	wire hostMode  = ctrl_reg[ltx_pkg::CTRL_HOST];

	always_comb begin
		rdMux = '0;
		if (selCtrl)
			rdMux[ltx_pkg::CTRL_W-1:0] = ctrl_reg;
		else if (selOe)
			rdMux[NCH-1:0] = oeForce_reg;
		else if (selStatus) begin
			rdMux[ltx_pkg::STAT_ONES +: NCH] = allOnesNow;
			rdMux[ltx_pkg::STAT_PDN +: NCH]  = powerDown;
			rdMux[ltx_pkg::STAT_TCLK +: NCH] = tclkSync;
			rdMux[ltx_pkg::STAT_MCLK]        = mclkRunning_reg;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_reg    <= ltx_pkg::CTRL_RESET;
			oeForce_reg <= NCH'(ltx_pkg::OE_RESET);
		end else if (regWrite) begin
			if (selCtrl)
				ctrl_reg <= regWrData[ltx_pkg::CTRL_W-1:0];
			if (selOe)
				oeForce_reg <= regWrData[NCH-1:0];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (sys_rst)
			regRdData_reg <= '0;
		else
			regRdData_reg <= regRead ? rdMux : '0;
	end
	assign regRdData = regRdData_reg;

	// ==========================================================
	// Pin synchronisers
	logic           mclkMeta, mclkSync, mclkPrev;
	logic           oeMeta, oeSync;
	logic [NCH-1:0] tclkMeta, tclkPrev;

	always_ff @(posedge clock) begin
		mclkMeta <= masterRefClock;
		mclkSync <= mclkMeta;
		oeMeta   <= outputEnableIn;
		oeSync   <= oeMeta;
		tclkMeta <= chanTxClock;
		tclkSync <= tclkMeta;
	end

	// No reset: a value unlike the pin level would fake an edge
	always_ff @(posedge clock) begin
		mclkPrev <= mclkSync;
		tclkPrev <= tclkSync;
	end

	wire            mclkRise = mclkSync & ~mclkPrev;
	wire            mclkEdge = mclkSync ^ mclkPrev;
	wire [NCH-1:0]  tclkEdge = tclkSync ^ tclkPrev;
	wire [NCH-1:0]  tclkRise = tclkSync & ~tclkPrev;

	// ==========================================================
	// Reference clock presence
	logic [MW-1:0] mclkIdle_reg;
	wire           mclkIdleFull = mclkIdle_reg >= MW'(MCLK_LOSS);

	always_ff @(posedge clock) begin
		if (sys_rst || mclkEdge)
			mclkIdle_reg <= '0;
		else if (!mclkIdleFull)
			mclkIdle_reg <= mclkIdle_reg + MW'(1);
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			mclkRunning_reg <= 1'b0;
		else
			mclkRunning_reg <= !mclkIdleFull;
	end

	// Static reference falls back to channel one's clock
	wire refTick = mclkRunning_reg ? mclkRise
		: tclkRise[ltx_pkg::REF_CHAN];                     // RULE10

	// ==========================================================
	// All-ones generator, one shared alternating mark
	logic aisPol_reg;

	always_ff @(posedge clock) begin
		if (sys_rst)
			aisPol_reg <= 1'b0;
		else if (refTick)
			aisPol_reg <= ~aisPol_reg;                     // RULE8
	end

	// ==========================================================
	// Per-channel coder and stall monitor
	wire [ltx_pkg::CFG_W-1:0] cfgBits = ctrl_reg[ltx_pkg::CFG_W-1:0];
	logic [NCH-1:0] encPos, encNeg;

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_chan
			ltx_line_encoder u_enc (
				.txClk     (chanTxClock[ch]),
				.sysRst    (sys_rst),
				.txSerial  (txSerialIn[ch]),
				.txPosRail (txPosRailIn[ch]),
				.txNegRail (txNegRailIn[ch]),
				.violIn    (violationInsertIn[ch]),
				.cfgIn     (cfgBits),
				.encPos    (encPos[ch]),
				.encNeg    (encNeg[ch])
			);
			ltx_clock_watch u_watch (
				.clock         (clock),
				.sys_rst       (sys_rst),
				.refTick       (refTick),
				.tclkLevel     (tclkSync[ch]),
				.tclkEdge      (tclkEdge[ch]),
				.allOnes_reg   (allOnesNow[ch]),
				.powerDown_reg (powerDown[ch])
			);
		end
	endgenerate

	// ==========================================================
	// Coded rails back into the system domain
	logic [NCH-1:0] encPosMeta, encPosSync, encNegMeta, encNegSync;

	always_ff @(posedge clock) begin
		encPosMeta <= encPos;
		encPosSync <= encPosMeta;
		encNegMeta <= encNeg;
		encNegSync <= encNegMeta;
	end

	// ==========================================================
	// Line driver
	wire [NCH-1:0] hostForce  = hostMode ? oeForce_reg : '0;   // RULE12
	wire [NCH-1:0] enableNext = {NCH{oeSync}} & ~powerDown
		& ~hostForce;                                      // RULE11
	// Rails cross bit by bit; a skewed pair must never show both marks
	wire [NCH-1:0] posNext    = (allOnesNow & {NCH{aisPol_reg}})
		| (~allOnesNow & encPosSync & ~encNegSync);        // RULE8
	wire [NCH-1:0] negNext    = (allOnesNow & {NCH{~aisPol_reg}})
		| (~allOnesNow & encNegSync & ~encPosSync);        // RULE2

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lineDrivePos    <= '0;
			lineDriveNeg    <= '0;
			lineDriveEnable <= '0;
			allOnesSend     <= '0;
		end else begin
			lineDrivePos    <= posNext;
			lineDriveNeg    <= negNext;
			lineDriveEnable <= enableNext;                 // RULE9
			allOnesSend     <= allOnesNow;                 // RULE7
		end
	end

	// ==========================================================
	// Checks
	a_oe_pin_hiz: assert property (            // RULE11
		@(posedge clock) disable iff (sys_rst)
		!oeSync |=> lineDriveEnable == '0)
		else $error("driver enabled while output enable low");
	a_host_force_hiz: assert property (        // RULE12
		@(posedge clock) disable iff (sys_rst)
		hostMode && oeForce_reg != '0
		|=> (lineDriveEnable & $past(oeForce_reg)) == '0)
		else $error("forced channel still driving");
	a_power_down_hiz: assert property (        // RULE9
		@(posedge clock) disable iff (sys_rst)
		powerDown != '0 |=> (lineDriveEnable & $past(powerDown)) == '0)
		else $error("powered down channel still driving");
	a_ones_ref_timed: assert property (        // RULE8
		@(posedge clock) disable iff (sys_rst)
		(refTick && allOnesNow[0]) ##1 allOnesNow[0]
		|=> lineDrivePos[0] == $past(aisPol_reg)
			&& lineDriveNeg[0] == !lineDrivePos[0])
		else $error("all ones pattern not following reference");
	a_ones_flag_out: assert property (         // RULE7
		@(posedge clock) disable iff (sys_rst)
		allOnesNow[0] ##1 allOnesNow[0] |-> allOnesSend[0])
		else $error("all ones flag not shown at output");
endmodule

// >>> tb/ltx_framer_model.sv
// Purpose: Far-side framer model: channel clocks and transmit data.
// Assumes: One 12 ns link clock, unrelated in phase to the system clock.
// Notes:   A stopped channel holds its idle level while its data scrambles.
`timescale 1ns/10ps
module ltx_framer_model #(
	parameter int NCH = 8
) (
	input  wire logic [NCH-1:0] runEn,
	input  wire logic [NCH-1:0] idleLvl,
	input  wire logic [NCH-1:0] serData,
	input  wire logic [NCH-1:0] serToggle,
	input  wire logic [NCH-1:0] posData,
	input  wire logic [NCH-1:0] negData,
	input  wire logic [NCH-1:0] violData,
	output logic [NCH-1:0]      chanTxClock,
	output logic [NCH-1:0]      txSerialIn,
	output logic [NCH-1:0]      txPosRailIn,
	output logic [NCH-1:0]      txNegRailIn,
	output logic [NCH-1:0]      violationInsertIn
);
	logic           linkPhase;
	logic [NCH-1:0] runQ;

	initial begin
		linkPhase = 1'b0;
		runQ = '0;
		txSerialIn = '0;
		txPosRailIn = '0;
		txNegRailIn = '0;
		violationInsertIn = '0;
		#3.7;
		forever #6 linkPhase = ~linkPhase;
	end

	// Gate only when the phase equals the idle level: no runt pulses
	always @(linkPhase) begin
		for (int i = 0; i < NCH; i++) begin
			if (idleLvl[i] == linkPhase) begin
				runQ[i] <= runEn[i];
			end
		end
	end
	assign chanTxClock = (runQ & {NCH{linkPhase}}) | (~runQ & idleLvl);

	// Launch on rising edge so data is settled at the falling edge
	always @(posedge linkPhase) begin
		for (int i = 0; i < NCH; i++) begin
			violationInsertIn[i] <= violData[i];
			if (runQ[i]) begin
				txSerialIn[i] <= serToggle[i] ? ~txSerialIn[i] : serData[i];
				txPosRailIn[i] <= posData[i];
				txNegRailIn[i] <= negData[i];
			end else begin
				// Nothing is clocked in, so show changing junk
				txSerialIn[i] <= ~txSerialIn[i];
				txPosRailIn[i] <= ~txPosRailIn[i];
				txNegRailIn[i] <= ~txNegRailIn[i];
			end
		end
	end
endmodule

// >>> tb/tb.sv
// Purpose: Self-checking bench of the transmit data port.
// Assumes: Short reference loss limit and a fast reference clock.
// Notes:   Line marks are watched on one channel chosen by monCh.
`timescale 1ns/10ps
module tb;
	localparam int NCH = 8;
	logic clock, sys_rst, regWrite, regRead, masterRefClock;
	logic outputEnableIn, refRun;
	logic [3:0] regAddr;
	logic [31:0] regWrData, regRdData, rdv;
	logic [NCH-1:0] chanTxClock, txSerialIn, txPosRailIn, txNegRailIn;
	logic [NCH-1:0] violationInsertIn, lineDrivePos, lineDriveNeg;
	logic [NCH-1:0] lineDriveEnable, allOnesSend;
	logic [NCH-1:0] runEn, idleLvl, serData, serToggle, posData, negData;
	logic [NCH-1:0] violData;
	logic [1:0] prevLine, lastMark;
	int miscompares, total_checks, markCount, sameCount, monCh;
	wire [1:0] monLine = {lineDrivePos[monCh], lineDriveNeg[monCh]};

	ltx_tx_port #(.NCH(NCH), .MCLK_LOSS(20)) uut (.clock(clock),
		.sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.masterRefClock(masterRefClock), .outputEnableIn(outputEnableIn),
		.chanTxClock(chanTxClock), .txSerialIn(txSerialIn),
		.txPosRailIn(txPosRailIn), .txNegRailIn(txNegRailIn),
		.violationInsertIn(violationInsertIn), .lineDrivePos(lineDrivePos),
		.lineDriveNeg(lineDriveNeg), .lineDriveEnable(lineDriveEnable),
		.allOnesSend(allOnesSend));
	ltx_framer_model #(.NCH(NCH)) far (.runEn(runEn), .idleLvl(idleLvl),
		.serData(serData), .serToggle(serToggle), .posData(posData),
		.negData(negData), .violData(violData), .chanTxClock(chanTxClock),
		.txSerialIn(txSerialIn), .txPosRailIn(txPosRailIn),
		.txNegRailIn(txNegRailIn), .violationInsertIn(violationInsertIn));

	// ==========================================================
	// Clocks and mark monitor
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		masterRefClock = 1'b0;
		forever #20 masterRefClock = refRun ? ~masterRefClock : masterRefClock;
	end
	always @(posedge clock) begin
		if (monLine != prevLine && monLine != 2'b00) begin
			markCount++;
			if (monLine == lastMark) sameCount++;
			lastMark = monLine;
		end
		prevLine = monLine;
	end

	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic ns(input int t);
		#t;
		@(posedge clock);
	endtask
	task automatic clear_mon(input int ch);
		monCh = ch;
		markCount = 0;
		sameCount = 0;
		lastMark = 2'b00;
	endtask
	// Config may only change while the channel clocks are stopped
	task automatic cfg(input logic [4:0] v);
		runEn <= '0;
		ns(60);
		wr(ltx_pkg::ADDR_CTRL, {27'h0, v});
		rd(ltx_pkg::ADDR_CTRL, rdv);
		check(rdv, {27'h0, v});
		runEn <= '1;
		ns(150);
	endtask
	task automatic viol_pulse(input int ch);
		violData[ch] <= 1'b1;
		ns(100);
		violData[ch] <= 1'b0;
		ns(300);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		wrap_up();
	end

	// ==========================================================
	// Tests
	initial begin
		{regWrite, regRead, regAddr, regWrData} = '0;
		{idleLvl, serData, serToggle, posData, negData, violData} = '0;
		runEn = '1;
		refRun = 1'b1;
		outputEnableIn = 1'b1;
		sys_rst = 1'b1;
		{miscompares, total_checks, monCh} = '0;
		prevLine = 2'b00;
		clear_mon(0);
		// Long enough for two link falling edges as well
		repeat (10) @(posedge clock);
		check({allOnesSend, lineDriveEnable}, 16'h0000);
		sys_rst <= 1'b0;
		rd(ltx_pkg::ADDR_OE, rdv);
		check(rdv, 32'h0);
		wr(4'hC, 32'hFFFFFFFF);
		rd(4'hC, rdv);
		check(rdv, 32'h0);
		// Dual rail: channels 0..3 carry codes 00, 01, 10, 11
		posData <= 8'h0C;
		negData <= 8'h0A;
		cfg(5'h01);
		check(lineDrivePos[3:0], 4'h4);
		check(lineDriveNeg[3:0], 4'h2);
		check(lineDriveEnable, 8'hFF);
		outputEnableIn <= 1'b0;
		ns(50);
		check(lineDriveEnable, 8'h00);
		outputEnableIn <= 1'b1;
		cfg(5'h11);
		wr(ltx_pkg::ADDR_OE, 32'h2);
		rd(ltx_pkg::ADDR_OE, rdv);
		check(rdv, 32'h2);
		ns(30);
		check(lineDriveEnable, 8'hFD);
		wr(ltx_pkg::ADDR_OE, 32'h0);
		// Channels 0 and 2 stalled high, channel 3 stalled low
		idleLvl <= 8'h05;
		runEn <= 8'hF2;
		ns(1000);
		check(allOnesSend, 8'h05);
		check(lineDriveEnable[2], 1'b1);
		clear_mon(2);
		ns(400);
		check(markCount >= 8 && markCount <= 12, 1'b1);
		check(sameCount, 32'h0);
		ns(2600);
		check(lineDriveEnable, 8'hF7);
		rd(ltx_pkg::ADDR_STATUS, rdv);
		check(rdv[15:0], 16'h0805);
		runEn <= '1;
		ns(300);
		check({allOnesSend, lineDriveEnable}, 16'h00FF);
		// Reference stopped: channel one clock times the stalls
		refRun = 1'b0;
		idleLvl <= 8'h10;
		runEn <= 8'hCF;
		ns(1500);
		check(allOnesSend, 8'h10);
		check(lineDriveEnable, 8'hDF);
		rd(ltx_pkg::ADDR_STATUS, rdv);
		check(rdv[24], 1'b0);
		refRun = 1'b1;
		runEn <= '1;
		ns(300);
		check({allOnesSend, lineDriveEnable}, 16'h00FF);
		// Single rail AMI, data 1010: marks alternate except one repeat from a mode 2 violation
		serToggle <= 8'hFF;
		cfg(5'h02);
		clear_mon(6);
		ns(600);
		check(markCount > 10, 1'b1);
		viol_pulse(6);
		check(sameCount, 32'h0);
		cfg(5'h06);
		clear_mon(6);
		viol_pulse(6);
		check(sameCount, 32'h1);
		// All zeros: AMI (both delays) silent, B8ZS and HDB3 substitute
		serToggle <= '0;
		for (int k = 0; k < 4; k++) begin
			cfg(k == 0 ? 5'h02 : k == 1 ? 5'h0A : k == 2 ? 5'h00 : 5'h08);
			clear_mon(6);
			ns(600);
			if (k < 2)
				check(markCount, 32'h0);
			else
				check(markCount > 0, 1'b1);
		end
		wrap_up();
	end
endmodule
